// ===== src/nrdiv_pkg.sv
// Package of constants and types for the divide step datapath
package nrdiv_pkg;
  localparam int ACC_W       = 36;
  localparam int DIVS_W      = 16;
  localparam int LOW_W       = 16;
  localparam int HI_W        = 20;
  localparam int ACC_MSB     = 35;
  localparam int DIVS_MSB    = 15;
  localparam int STEP_CYCLES = 2;
  localparam logic [35:0] ACC_RST   = 36'h0_0000_0000;
  localparam logic [15:0] DIVS_RST  = 16'h0000;

  typedef enum logic [1:0]
  {
    NRDIV_IDLE = 2'b01,
    NRDIV_EXEC = 2'b10
  } nrdiv_state_t;
endpackage

// ===== src/nrdiv_step_if.sv
// Interface carrying one divide step between the control and arithmetic parts
`timescale 1ns/1ns
interface nrdiv_step_if;
  logic [35:0] acc_in;
  logic [15:0] divs;
  logic        carry_in;
  logic [35:0] acc_out;
  logic        carry_out;
  logic        ovf_out;
  modport ctrl (output acc_in, output divs, output carry_in,
                input acc_out, input carry_out, input ovf_out);
  modport alu  (input acc_in, input divs, input carry_in,
                output acc_out, output carry_out, output ovf_out);
endinterface

// ===== src/nrdiv_alu.sv
// Combinational arithmetic of one non-restoring divide step
`timescale 1ns/1ns
module nrdiv_alu
(
  nrdiv_step_if.alu      step
);
  import nrdiv_pkg::*;

  logic              sel_add;
  logic [35:0]       shifted;
  logic [19:0]       divs_ext;
  logic [19:0]       upper_res;

  always_comb
  begin
    sel_add   = step.acc_in[ACC_MSB] ^ step.divs[DIVS_MSB];
    shifted   = {step.acc_in[34:0], step.carry_in};
    divs_ext  = {{4{step.divs[DIVS_MSB]}}, step.divs};
    if (sel_add)
    begin
      upper_res = shifted[35:16] + divs_ext;
    end
    else
    begin
      upper_res = shifted[35:16] - divs_ext;
    end
    step.acc_out   = {upper_res, shifted[15:0]};
    step.carry_out = ~upper_res[HI_W-1];
    step.ovf_out   = step.acc_in[ACC_MSB] ^ step.acc_in[ACC_MSB-1];
  end
endmodule

// ===== src/nrdiv_top.sv
// Divide step datapath top: accumulator, divisor, flags and step timing
`timescale 1ns/1ns
// Behaviour
// - Divisor is a signed 16-bit two's complement value.
// - Operation chosen by XOR of accumulator bit 35 and divisor bit 15.
// - Accumulator shifts left one place, carry enters bit 0.
// - Divisor added to upper part if XOR is one, else subtracted.
// - Divisor sign-extended so the operation's carry is the next quotient bit.
// - Upper part holds partial remainder, low word the formed quotient.
// - Limit flag set whenever a step sets overflow.
// - Overflow set when the shift changes the accumulator's top bit.
// - Carry set when result bit 35 is zero, cleared otherwise.
// - A step completes in two clock cycles.
module nrdiv_top
(
  // Clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  // Loads from the core
  input  wire logic                        i_acc_load,
  input  wire logic [nrdiv_pkg::ACC_W-1:0] i_acc_data,
  input  wire logic                        i_divs_load,
  input  wire logic [nrdiv_pkg::DIVS_W-1:0] i_divs_data,
  input  wire logic                        i_carry_load,
  input  wire logic                        i_carry_data,
  input  wire logic                        i_limit_clr,
  // Step request
  input  wire logic                        i_step,
  // Results
  output logic [nrdiv_pkg::ACC_W-1:0]      o_acc,
  output logic [nrdiv_pkg::LOW_W-1:0]      o_acc_low_word,
  output logic [nrdiv_pkg::HI_W-1:0]       o_acc_upper_word,
  output logic                             o_carry,
  output logic                             o_ovf,
  output logic                             o_limit,
  output logic                             o_busy,
  output logic                             o_done
);
  import nrdiv_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  nrdiv_state_t      state_q;
  nrdiv_state_t      state_d;
  logic [35:0]       acc_q;
  logic [15:0]       divs_q;
  logic              carry_q;
  logic              ovf_q;
  logic              limit_q;
  logic              done_q;
  logic              busy_q;
  logic              finish;

  nrdiv_step_if      step ();

  assign step.acc_in   = acc_q;
  assign step.divs     = divs_q;
  assign step.carry_in = carry_q;

  nrdiv_alu u_alu
  (
    .step (step)
  );

  // ----------------------------------------
  // Step timing
  // ----------------------------------------
  assign finish = (state_q == NRDIV_EXEC);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      NRDIV_IDLE:
      begin
        if (i_step)
        begin
          state_d = NRDIV_EXEC;
        end
      end
      NRDIV_EXEC:
      begin
        state_d = NRDIV_IDLE;
      end
      default:
      begin
        state_d = NRDIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= NRDIV_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= finish;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_d == NRDIV_EXEC);
    end
  end

  // ----------------------------------------
  // Accumulator and divisor
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_q <= ACC_RST;
    end
    else if (finish)
    begin
      acc_q <= step.acc_out;
    end
    else if (i_acc_load)
    begin
      acc_q <= i_acc_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      divs_q <= DIVS_RST;
    end
    else if (i_divs_load && !finish)
    begin
      divs_q <= i_divs_data;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      carry_q <= 1'b0;
    end
    else if (finish)
    begin
      carry_q <= step.carry_out;
    end
    else if (i_carry_load)
    begin
      carry_q <= i_carry_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ovf_q <= 1'b0;
    end
    else if (finish)
    begin
      ovf_q <= step.ovf_out;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      limit_q <= 1'b0;
    end
    else if (finish && step.ovf_out)
    begin
      limit_q <= 1'b1;
    end
    else if (i_limit_clr)
    begin
      limit_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_acc            = acc_q;
  assign o_acc_low_word   = acc_q[15:0];
  assign o_acc_upper_word = acc_q[35:16];
  assign o_carry          = carry_q;
  assign o_ovf            = ovf_q;
  assign o_limit          = limit_q;
  assign o_busy           = busy_q;
  assign o_done           = done_q;
endmodule

// ===== verif/nrdiv_chk.sv
// Checker of the divide step outputs
`timescale 1ns/1ns
module nrdiv_chk
(
  // Clock, reset and requests
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_step,
  input wire logic        i_limit_clr,
  // Results
  input wire logic [35:0] o_acc,
  input wire logic        o_carry,
  input wire logic        o_ovf,
  input wire logic        o_limit,
  input wire logic        o_busy,
  input wire logic        o_done
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_step_two_cycles: assert property
    (i_step && !o_busy |=> o_busy ##1 o_done) else $error("step not done in two cycles");
  a_busy_one_cycle: assert property
    (o_busy |=> !o_busy) else $error("busy longer than one cycle");
  a_done_one_pulse: assert property
    (o_done |=> !o_done) else $error("done longer than one cycle");
  a_carry_from_msb: assert property
    (o_done |-> o_carry == !o_acc[35]) else $error("carry not inverse of bit 35");
  a_ovf_from_shift: assert property
    (o_done |-> o_ovf == ($past(o_acc[35]) ^ $past(o_acc[34]))) else $error("overflow wrong");
  a_low_word_shift: assert property
    (o_done |-> o_acc[15:0] == {$past(o_acc[14:0]), $past(o_carry)})
    else $error("low word not shifted");
  a_limit_on_ovf: assert property
    (o_done && o_ovf |-> o_limit) else $error("limit not set on overflow");
  a_limit_sticky: assert property
    (o_limit && !i_limit_clr |=> o_limit) else $error("limit dropped");
endmodule

// ===== verif/nrdiv_seq.sv
// Sequencer model issuing a run of divide steps
`timescale 1ns/1ns
module nrdiv_seq
(
  // Clock, reset and control
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_go,
  input wire logic [4:0] i_n,
  input wire logic       i_busy,
  input wire logic       i_done,
  // Step request
  output logic           o_step
);
  logic [4:0] left_q;
  always @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      o_step <= 1'b0;
      left_q <= 5'h00;
    end
    else if (i_go)
    begin
      o_step <= 1'b1;
      left_q <= i_n;
    end
    else if (o_step && i_busy)
    begin
      o_step <= 1'b0;
      left_q <= left_q - 5'h01;
    end
    else if (i_done && left_q != 5'h00)
      o_step <= 1'b1;
endmodule

// ===== verif/nrdiv_top_tb.sv
// Testbench of the divide step datapath
`timescale 1ns/1ns
module nrdiv_top_tb;
  logic        clk = 0, rst = 1, ald = 0, dld = 0, cld = 0, cd = 0, lclr = 0, go = 0;
  logic [35:0] ad = '0, acc, m;
  logic [15:0] dd = '0, low;
  logic [19:0] up;
  logic [4:0]  n = '0;
  logic        step, car, ovf, lim, busy, done, mc, ml;
  int          n_fail = 0, check_count = 0;

  nrdiv_top dut (.i_core_clk(clk), .i_rst(rst), .i_acc_load(ald), .i_acc_data(ad),
    .i_divs_load(dld), .i_divs_data(dd), .i_carry_load(cld), .i_carry_data(cd),
    .i_limit_clr(lclr), .i_step(step), .o_acc(acc), .o_acc_low_word(low),
    .o_acc_upper_word(up), .o_carry(car), .o_ovf(ovf), .o_limit(lim), .o_busy(busy),
    .o_done(done));
  nrdiv_seq seq (.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_n(n), .i_busy(busy),
    .i_done(done), .o_step(step));

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Loads operands, runs k steps, compares each step with the model
  task automatic run_div(input logic [35:0] a, input logic [15:0] d, input logic c,
                         input logic [4:0] k);
    logic        x, v;
    logic [35:0] sh;
    logic [19:0] h;
    int          t;
    @(negedge clk);
    {ad, dd, cd, ald, dld, cld, lclr} = {a, d, c, 4'hf};
    @(negedge clk);
    {ald, dld, cld, lclr, n, go} = {4'h0, k, 1'b1};
    {m, mc, ml} = {a, c, 1'b0};
    @(negedge clk);
    go = 0;
    repeat (k)
    begin
      x = m[35] ^ d[15];
      sh = {m[34:0], mc};
      h = x ? sh[35:16] + {{4{d[15]}}, d} : sh[35:16] - {{4{d[15]}}, d};
      v = m[35] ^ m[34];
      {m, mc, ml} = {h, sh[15:0], ~h[19], ml | v};
      t = 0;
      while (done !== 1'b1 && t < 20)
      begin
        @(negedge clk);
        t++;
      end
      if (done !== 1'b1)
      begin
        n_fail++;
        $display("Error at %0t: done %h expected %h", $time, done, 1'b1);
        close_out;
      end
      check_count++;
      if ({up, low, car, ovf, lim, acc} !== {m, mc, v, ml, m})
      begin
        n_fail++;
        $display("Error at %0t: got %h expected %h", $time, {acc, car, ovf, lim},
                 {m, mc, v, ml});
      end
      @(negedge clk);
    end
  endtask

  // Quarter over half: quotient 0.5, negative remainder restored to zero
  task automatic scen_half_quotient;
    run_div(36'h0_2000_0000, 16'h4000, 1'b0, 5'h10);
    check_count++;
    if ({up + 20'h04000, low, car} !== {20'h00000, 16'h4000, 1'b0})
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, {up + 20'h04000, low, car},
               {20'h00000, 16'h4000, 1'b0});
    end
  endtask

  // Negative divisor, full precision
  task automatic scen_neg_divisor;
    run_div(36'h0_1234_5678, 16'hc000, 1'b0, 5'h10);
  endtask

  // Top bits differ: shift overflow and sticky limit
  task automatic scen_overflow;
    run_div(36'h4_0000_0000, 16'h7fff, 1'b1, 5'h03);
  endtask

  // Single step after limit clear: limit stays low
  task automatic scen_single_step;
    run_div(36'hf_ffff_0001, 16'h0003, 1'b1, 5'h01);
  endtask

  initial
    forever #5 clk = ~clk;

  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 0;
    scen_half_quotient;
    scen_neg_divisor;
    scen_overflow;
    scen_single_step;
    close_out;
  end
endmodule

bind nrdiv_top nrdiv_chk chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_step(i_step),
  .i_limit_clr(i_limit_clr), .o_acc(o_acc), .o_carry(o_carry), .o_ovf(o_ovf),
  .o_limit(o_limit), .o_busy(o_busy), .o_done(o_done));
